//--- core/rcic_regs.sv
// Purpose: Control register bank with interrupt unit and channel assessment
// Assumes: Classic Wishbone slave, 40 MHz clk, radio inputs from same clock
// Notes: One ack cycle per access, then one idle cycle before the next
//
// Behaviour
// - Soft reset bits clear themselves after the reset is carried out.
// - Eight event sources share one interrupt output.
// - Enables at 0x32 gate sources; pending flags recorded at 0x31.
// - Reading the flag register returns flags and clears them all.
// - Interrupt output stays active until the flag register is read.
// - Bit 1 of 0x211 picks interrupt polarity; reset 0 means falling.
// - Flags and enables share bit positions, sleep at 7 down to tx at 0.
// - Channel is bits 7:4 of RF control 0, channels 11 to 26.
// - Assessment mode bits 7:6 of 0x3A: 10 energy, 01 carrier, 11 both.
// - Energy mode reports busy when energy exceeds threshold at 0x3F.
// - Carrier mode reports busy on carrier above threshold 0x3A[5:2].
// - Combined mode needs both carrier and energy above threshold.
// - MAC reset clears all registers; power and baseband resets keep them.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rcic_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] irqEvents,
    input wire logic [7:0] energyLevel,
    input wire logic [3:0] carrierLevel,
    output logic irqOut,
    output logic ccaBusy,
    output logic baseband_reset,
    output logic power_circuit_reset,
    output logic [3:0] rfChannel,
    output logic rf_fsm_reset
);
    rcic_pkg::rcic_state_t s_q, s_d;
    logic [11:0] idx;
    logic req, wr, rd, lane0;
    logic [7:0] wv;
    logic [7:0] newFlags;
    logic busyNow;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    assign idx = wb_adr_i[13:2];
    assign lane0 = wb_sel_i[0];
    assign wv = wb_dat_i[7:0];

    // ------------------------------------------------------------
    // Channel assessment
    // ------------------------------------------------------------
    always_comb begin
        logic en, cs;
        en = energyLevel > s_q.energyTh;
        cs = carrierLevel > s_q.assessment_mode[rcic_pkg::CS_TH_HI:rcic_pkg::CS_TH_LO];
        case (rcic_pkg::rcic_cca_t'(s_q.assessment_mode[rcic_pkg::MODE_HI:rcic_pkg::MODE_LO]))
            rcic_pkg::CCA_ENERGY: busyNow = en;
            rcic_pkg::CCA_CARRIER: busyNow = cs;
            rcic_pkg::CCA_BOTH: busyNow = cs && en;
            default: busyNow = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        req = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        s_d.radio.busy = busyNow;
        s_d.radio.bbReset = 1'b0;
        s_d.radio.pwrReset = 1'b0;
        s_d.softReset = rcic_pkg::RESET_VAL;
        case (s_q.bus)
            rcic_pkg::BUS_IDLE: begin
                req = wb_cyc_i && wb_stb_i;
                wr = req && wb_we_i && lane0;
                rd = req && !wb_we_i;
                if (req) begin
                    s_d.bus = rcic_pkg::BUS_ACK;
                end
            end
            rcic_pkg::BUS_ACK: s_d.bus = rcic_pkg::BUS_GAP;
            rcic_pkg::BUS_GAP: s_d.bus = rcic_pkg::BUS_IDLE;
            default: s_d.bus = rcic_pkg::BUS_IDLE;
        endcase
        // Set wins over read-clear so no event is lost
        newFlags = irqEvents;
        if (rd && hit(idx, rcic_pkg::IDX_IRQ_FLAGS)) begin
            s_d.irqFlags = newFlags;
        end else begin
            s_d.irqFlags = s_q.irqFlags | newFlags;
        end
        s_d.irqPending = |(s_d.irqFlags & s_q.irqEnables);
        if (wr) begin
            case (idx)
                rcic_pkg::IDX_PA_TIMING: s_d.paTiming = wv;
                rcic_pkg::IDX_TX_STAB: s_d.txStab = wv;
                rcic_pkg::IDX_IRQ_ENABLES: s_d.irqEnables = wv;
                rcic_pkg::IDX_RF_STATE: s_d.rfState = wv;
                rcic_pkg::IDX_CCA_MODE: s_d.assessment_mode = wv;
                rcic_pkg::IDX_RSSI_MODE: s_d.rssiMode = wv;
                rcic_pkg::IDX_ENERGY_TH: s_d.energyTh = wv;
                rcic_pkg::IDX_CHANNEL: s_d.channel = wv;
                rcic_pkg::IDX_VCO_OPT: s_d.vco_option_field = wv;
                rcic_pkg::IDX_SYNTH: s_d.synth = wv;
                rcic_pkg::IDX_TX_FILTER: s_d.txFilter = wv;
                rcic_pkg::IDX_SLEEP_CLK: s_d.sleepClk = wv;
                rcic_pkg::IDX_VCO_CTRL: s_d.vcoCtrl = wv;
                rcic_pkg::IDX_IRQ_POL: s_d.irqPol = wv;
                rcic_pkg::IDX_CLK_DIV: s_d.clkDiv = wv;
                rcic_pkg::IDX_SOFT_RESET: begin
                    s_d.softReset = wv & rcic_pkg::SOFT_RST_MASK;
                    s_d.radio.bbReset = wv[rcic_pkg::BIT_RST_BB];
                    s_d.radio.pwrReset = wv[rcic_pkg::BIT_RST_PWR];
                end
                default: ;
            endcase
        end
        s_d.rdat = '0;
        if (rd) begin
            case (idx)
                rcic_pkg::IDX_PA_TIMING: s_d.rdat[7:0] = s_q.paTiming;
                rcic_pkg::IDX_SOFT_RESET: s_d.rdat[7:0] = s_q.softReset;
                rcic_pkg::IDX_TX_STAB: s_d.rdat[7:0] = s_q.txStab;
                rcic_pkg::IDX_IRQ_FLAGS: s_d.rdat[7:0] = s_q.irqFlags;
                rcic_pkg::IDX_IRQ_ENABLES: s_d.rdat[7:0] = s_q.irqEnables;
                rcic_pkg::IDX_RF_STATE: s_d.rdat[7:0] = s_q.rfState;
                rcic_pkg::IDX_CCA_MODE: s_d.rdat[7:0] = s_q.assessment_mode;
                rcic_pkg::IDX_RSSI_MODE: s_d.rdat[7:0] = s_q.rssiMode;
                rcic_pkg::IDX_ENERGY_TH: s_d.rdat[7:0] = s_q.energyTh;
                rcic_pkg::IDX_CHANNEL: s_d.rdat[7:0] = s_q.channel;
                rcic_pkg::IDX_VCO_OPT: s_d.rdat[7:0] = s_q.vco_option_field;
                rcic_pkg::IDX_SYNTH: s_d.rdat[7:0] = s_q.synth;
                rcic_pkg::IDX_TX_FILTER: s_d.rdat[7:0] = s_q.txFilter;
                rcic_pkg::IDX_SLEEP_CLK: s_d.rdat[7:0] = s_q.sleepClk;
                rcic_pkg::IDX_VCO_CTRL: s_d.rdat[7:0] = s_q.vcoCtrl;
                rcic_pkg::IDX_IRQ_POL: s_d.rdat[7:0] = s_q.irqPol;
                rcic_pkg::IDX_CLK_DIV: s_d.rdat[7:0] = s_q.clkDiv;
                rcic_pkg::IDX_STATUS: begin
                    s_d.rdat[7:0] = (s_q.irqPending ? rcic_pkg::ST_IRQ_BIT : 8'h00)
                        | (s_q.radio.busy ? rcic_pkg::ST_BUSY_BIT : 8'h00)
                        | (s_q.radio.bbReset ? rcic_pkg::ST_BB_RST_BIT : 8'h00)
                        | (s_q.radio.pwrReset ? rcic_pkg::ST_PWR_RST_BIT : 8'h00);
                end
                default: s_d.rdat = '0;
            endcase
        end
        // MAC reset returns every control register to its reset value
        if (wr && hit(idx, rcic_pkg::IDX_SOFT_RESET) && wv[rcic_pkg::BIT_RST_MAC]) begin
            s_d.paTiming = rcic_pkg::RESET_VAL;
            s_d.txStab = rcic_pkg::RESET_VAL;
            s_d.irqFlags = rcic_pkg::RESET_VAL;
            s_d.irqEnables = rcic_pkg::RESET_VAL;
            s_d.rfState = rcic_pkg::RESET_VAL;
            s_d.assessment_mode = rcic_pkg::RESET_VAL;
            s_d.rssiMode = rcic_pkg::RESET_VAL;
            s_d.energyTh = rcic_pkg::RESET_VAL;
            s_d.channel = rcic_pkg::RESET_VAL;
            s_d.vco_option_field = rcic_pkg::RESET_VAL;
            s_d.synth = rcic_pkg::RESET_VAL;
            s_d.txFilter = rcic_pkg::RESET_VAL;
            s_d.sleepClk = rcic_pkg::RESET_VAL;
            s_d.vcoCtrl = rcic_pkg::RESET_VAL;
            s_d.irqPol = rcic_pkg::RESET_VAL;
            s_d.clkDiv = rcic_pkg::RESET_VAL;
            s_d.irqPending = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.bus <= rcic_pkg::BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Polarity applied to a registered level; a change while idle moves
    // the resting level, which is the only way an edge pin can follow it
    assign irqOut = s_q.irqPol[rcic_pkg::BIT_IRQ_EDGE] ? s_q.irqPending : !s_q.irqPending;
    assign wb_ack_o = s_q.bus == rcic_pkg::BUS_ACK;
    assign wb_dat_o = s_q.rdat;
    assign ccaBusy = s_q.radio.busy;
    assign baseband_reset = s_q.radio.bbReset;
    assign power_circuit_reset = s_q.radio.pwrReset;
    assign rfChannel = s_q.channel[7:4];
    assign rf_fsm_reset = s_q.rfState[rcic_pkg::BIT_RF_FSM_RST];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_softClear;
        @(posedge clk) disable iff (sys_rst)
        s_q.softReset != 8'h00 |=> s_q.softReset == 8'h00 || $past(wr);
    endproperty
    a_softClear: assert property (p_softClear) else $error("soft reset bits stuck");

    property p_readClear;
        @(posedge clk) disable iff (sys_rst)
        (rd && idx == rcic_pkg::IDX_IRQ_FLAGS && irqEvents == 8'h00) |=> s_q.irqFlags == 8'h00;
    endproperty
    a_readClear: assert property (p_readClear) else $error("flags not cleared by read");

    property p_flagSet;
        @(posedge clk) disable iff (sys_rst)
        (irqEvents != 8'h00 && !wr) |=> (s_q.irqFlags & $past(irqEvents)) == $past(irqEvents);
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("event lost");

    property p_irqHold;
        @(posedge clk) disable iff (sys_rst)
        (s_q.irqPending && !rd && !wr) |=> s_q.irqPending;
    endproperty
    a_irqHold: assert property (p_irqHold) else $error("interrupt dropped early");

    property p_polarity;
        @(posedge clk) disable iff (sys_rst)
        irqOut == (s_q.irqPending ~^ s_q.irqPol[1]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("interrupt polarity wrong");

    property p_energy;
        @(posedge clk) disable iff (sys_rst)
        (s_q.assessment_mode[7:6] == 2'b10) |=> ccaBusy == ($past(energyLevel) > $past(s_q.energyTh));
    endproperty
    a_energy: assert property (p_energy) else $error("energy mode busy wrong");

    property p_both;
        @(posedge clk) disable iff (sys_rst)
        (s_q.assessment_mode[7:6] == 2'b11 && energyLevel <= s_q.energyTh) |=> !ccaBusy;
    endproperty
    a_both: assert property (p_both) else $error("combined mode busy without energy");

    property p_ackPulse;
        @(posedge clk) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack not single cycle");
endmodule
`default_nettype wire

//--- core/rcic_pkg.sv
// Purpose: Constants and types for the radio control register bank
// Assumes: Classic Wishbone, 32-bit data, byte address = 4 * register index
// Notes: Register indices are kept as printed; bus address is index << 2
package rcic_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_PA_TIMING = 12'h018;
    localparam logic [11:0] IDX_SOFT_RESET = 12'h02a;
    localparam logic [11:0] IDX_TX_STAB = 12'h02e;
    localparam logic [11:0] IDX_IRQ_FLAGS = 12'h031;
    localparam logic [11:0] IDX_IRQ_ENABLES = 12'h032;
    localparam logic [11:0] IDX_RF_STATE = 12'h036;
    localparam logic [11:0] IDX_CCA_MODE = 12'h03a;
    localparam logic [11:0] IDX_RSSI_MODE = 12'h03e;
    localparam logic [11:0] IDX_ENERGY_TH = 12'h03f;
    localparam logic [11:0] IDX_CHANNEL = 12'h200;
    localparam logic [11:0] IDX_VCO_OPT = 12'h201;
    localparam logic [11:0] IDX_SYNTH = 12'h202;
    localparam logic [11:0] IDX_TX_FILTER = 12'h206;
    localparam logic [11:0] IDX_SLEEP_CLK = 12'h207;
    localparam logic [11:0] IDX_VCO_CTRL = 12'h208;
    localparam logic [11:0] IDX_IRQ_POL = 12'h211;
    localparam logic [11:0] IDX_CLK_DIV = 12'h220;
    localparam logic [11:0] IDX_STATUS = 12'h3f0;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int BIT_RST_MAC = 0;
    localparam int BIT_RST_BB = 1;
    localparam int BIT_RST_PWR = 2;
    localparam int BIT_IRQ_EDGE = 1;
    localparam int BIT_RF_FSM_RST = 2;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int CS_TH_HI = 5;
    localparam int CS_TH_LO = 2;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] SOFT_RST_MASK = 8'h07;
    localparam logic [7:0] ST_IRQ_BIT = 8'h01;
    localparam logic [7:0] ST_BUSY_BIT = 8'h02;
    localparam logic [7:0] ST_BB_RST_BIT = 8'h04;
    localparam logic [7:0] ST_PWR_RST_BIT = 8'h08;
    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CCA_NONE = 2'b00,
        CCA_CARRIER = 2'b01,
        CCA_ENERGY = 2'b10,
        CCA_BOTH = 2'b11
    } rcic_cca_t;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_GAP = 3'b100
    } rcic_bus_t;
    typedef struct packed {
        logic busy;
        logic bbReset;
        logic pwrReset;
    } rcic_radio_out_t;
    typedef struct packed {
        rcic_bus_t bus;
        logic [31:0] rdat;
        logic [7:0] paTiming;
        logic [7:0] softReset;
        logic [7:0] txStab;
        logic [7:0] irqFlags;
        logic [7:0] irqEnables;
        logic [7:0] rfState;
        logic [7:0] assessment_mode;
        logic [7:0] rssiMode;
        logic [7:0] energyTh;
        logic [7:0] channel;
        logic [7:0] vco_option_field;
        logic [7:0] synth;
        logic [7:0] txFilter;
        logic [7:0] sleepClk;
        logic [7:0] vcoCtrl;
        logic [7:0] irqPol;
        logic [7:0] clkDiv;
        logic irqPending;
        rcic_radio_out_t radio;
    } rcic_state_t;
endpackage

//--- tb/rcic_host.sv
// Purpose: Host model driving the register bank over classic Wishbone
// Assumes: One request at a time, ack sampled at the rising edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module rcic_host (
    input wire logic clk,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [13:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    input wire logic ack
);
    // ------------------------------------------------------------
    // Setup table, register index then value
    // ------------------------------------------------------------
    localparam logic [19:0] INIT_TAB [13] = '{20'h02a07, 20'h01898, 20'h02e95, 20'h20003,
        20'h20102, 20'h20280, 20'h20690, 20'h20780, 20'h20810, 20'h22021, 20'h03a80,
        20'h03f60, 20'h03e40};
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 14'h0000;
        sel = 4'h0;
        dat = 32'h00000000;
    end
    task automatic xfer(input logic [11:0] idx, input logic w, input logic [7:0] d,
            input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat <= {24'h000000, d};
        // Ack is read just after the edge, before that edge's updates land
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~{idx, 2'b00};
        dat <= ~{24'h000000, d};
    endtask
    task automatic rf_reset(input int settle);
        xfer(rcic_pkg::IDX_RF_STATE, 1'b1, 8'h04, 4'h1);
        xfer(rcic_pkg::IDX_RF_STATE, 1'b1, 8'h00, 4'h1);
        repeat (settle) @(posedge clk);
    endtask
    task automatic init_seq();
        for (int k = 0; k < 13; k++) begin
            xfer(INIT_TAB[k][19:8], 1'b1, INIT_TAB[k][7:0], 4'h1);
        end
        rf_reset(7680);
    endtask
    task automatic set_channel(input logic [3:0] ch, input int settle);
        xfer(rcic_pkg::IDX_CHANNEL, 1'b1, {ch, 4'h3}, 4'h1);
        rf_reset(settle);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the radio control register bank
// Assumes: Host model issues every bus cycle
// Notes: Reads note their expectation in a queue checked at ack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic sysRst, wbCyc, wbStb, wbWe, wbAck, irqOut, ccaBusy, bbRst, pwrRst, rfFsmRst, b;
    logic [13:0] wbAdr;
    logic [3:0] wbSel, carrierLevel, rfChannel;
    logic [31:0] wbDatI, wbDatO, rng, expQ[$], mskQ[$];
    logic [7:0] irqEvents, energyLevel, cm;
    int failures = 0, nCompared = 0, cycles = 0, bbCnt = 0, pwrCnt = 0;
    always #12.5 clk = ~clk;
    rcic_host i_rcic_host (.clk(clk), .cyc(wbCyc), .stb(wbStb), .we(wbWe), .adr(wbAdr),
        .sel(wbSel), .dat(wbDatI), .ack(wbAck));
    rcic_regs i_rcic_regs (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irqEvents(irqEvents), .energyLevel(energyLevel),
        .carrierLevel(carrierLevel), .irqOut(irqOut), .ccaBusy(ccaBusy),
        .baseband_reset(bbRst), .power_circuit_reset(pwrRst), .rfChannel(rfChannel),
        .rf_fsm_reset(rfFsmRst));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic [31:0] msk);
        expQ.push_back(exp);
        mskQ.push_back(msk);
        i_rcic_host.xfer(idx, 1'b0, 8'h00, 4'hf);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        i_rcic_host.xfer(idx, 1'b1, d, 4'h1);
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk);
        irqEvents <= ev;
        @(posedge clk);
        irqEvents <= 8'h00;
        repeat (2) @(negedge clk);
    endtask
    // Scoreboard and pulse counters sample between edges
    always @(negedge clk) begin
        if (bbRst === 1'b1) bbCnt++;
        if (pwrRst === 1'b1) pwrCnt++;
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            check("read data", expQ[0] & mskQ[0], wbDatO & mskQ[0]);
            expQ.delete(0);
            mskQ.delete(0);
        end
    end
    // Ceiling sits well above the longest run of about 16200 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sysRst = 1'b1;
        irqEvents = 8'h00;
        energyLevel = 8'h00;
        carrierLevel = 4'h0;
        rng = 32'h18a3bd0c;
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        @(negedge clk);
        check("irqOut idle", 32'h1, {31'h0, irqOut});
        rd(rcic_pkg::IDX_IRQ_POL, 32'h0, 32'hff);
        i_rcic_host.init_seq();
        for (int k = 1; k < 13; k++) begin
            rd(i_rcic_host.INIT_TAB[k][19:8], {24'h0, i_rcic_host.INIT_TAB[k][7:0]}, 32'hff);
        end
        rd(rcic_pkg::IDX_SOFT_RESET, 32'h0, 32'hff);
        wr(rcic_pkg::IDX_SOFT_RESET, 8'h06);
        rd(rcic_pkg::IDX_PA_TIMING, 32'h98, 32'hff);
        check("reset pulses", 32'h22, bbCnt + pwrCnt * 16);
        wr(rcic_pkg::IDX_SOFT_RESET, 8'h01);
        rd(rcic_pkg::IDX_PA_TIMING, 32'h0, 32'hffffffff);
        rd(rcic_pkg::IDX_SOFT_RESET, 32'h0, 32'hff);
        wr(12'h100, 8'h5a);
        rd(12'h100, 32'h0, 32'hffffffff);
        wr(rcic_pkg::IDX_ENERGY_TH, 8'h5c);
        i_rcic_host.xfer(rcic_pkg::IDX_ENERGY_TH, 1'b1, 8'h33, 4'h2);
        rd(rcic_pkg::IDX_ENERGY_TH, 32'h5c, 32'hff);
        for (int c = 0; c < 16; c++) begin
            i_rcic_host.set_channel(c[3:0], (c == 15) ? 7680 : 2);
            check("rfChannel", c, {28'h0, rfChannel});
            rd(rcic_pkg::IDX_CHANNEL, {24'h0, c[3:0], 4'h3}, 32'hff);
        end
        wr(rcic_pkg::IDX_RF_STATE, 8'h04);
        @(negedge clk);
        check("rf_fsm_reset", 32'h1, {31'h0, rfFsmRst});
        wr(rcic_pkg::IDX_RF_STATE, 8'h00);
        @(negedge clk);
        check("rf_fsm_reset", 32'h0, {31'h0, rfFsmRst});
        wr(rcic_pkg::IDX_IRQ_ENABLES, 8'hff);
        for (int k = 0; k < 8; k++) begin
            pulse(8'h01 << k);
            repeat (4) @(negedge clk);
            check("irqOut held", 32'h0, {31'h0, irqOut});
            rd(rcic_pkg::IDX_IRQ_FLAGS, 32'h1 << k, 32'hff);
            repeat (2) @(negedge clk);
            check("irqOut freed", 32'h1, {31'h0, irqOut});
            rd(rcic_pkg::IDX_IRQ_FLAGS, 32'h0, 32'hff);
        end
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            wr(rcic_pkg::IDX_IRQ_ENABLES, rng[7:0]);
            pulse(rng[15:8]);
            check("irq gated", {31'h0, (rng[7:0] & rng[15:8]) == 8'h00}, {31'h0, irqOut});
            rd(rcic_pkg::IDX_IRQ_FLAGS, {24'h0, rng[15:8]}, {24'h0, rng[7:0]});
            repeat (2) @(negedge clk);
        end
        wr(rcic_pkg::IDX_IRQ_ENABLES, 8'hff);
        wr(rcic_pkg::IDX_IRQ_POL, 8'h02);
        repeat (2) @(negedge clk);
        check("irqOut new idle", 32'h0, {31'h0, irqOut});
        pulse(8'h08);
        check("irqOut high active", 32'h1, {31'h0, irqOut});
        rd(rcic_pkg::IDX_IRQ_FLAGS, 32'h08, 32'hff);
        repeat (2) @(negedge clk);
        check("irqOut released", 32'h0, {31'h0, irqOut});
        for (int k = 0; k < 40; k++) begin
            rng = xs(rng);
            cm = {k[1:0], rng[5:2], 2'b00};
            wr(rcic_pkg::IDX_CCA_MODE, cm);
            wr(rcic_pkg::IDX_ENERGY_TH, rng[15:8]);
            @(posedge clk);
            energyLevel <= rng[23:16];
            carrierLevel <= rng[27:24];
            repeat (2) @(negedge clk);
            b = (cm[7] | cm[6]) & (!cm[7] | (rng[23:16] > rng[15:8]))
                & (!cm[6] | (rng[27:24] > cm[5:2]));
            check("ccaBusy", {31'h0, b}, {31'h0, ccaBusy});
        end
        close_out();
    end
endmodule
`default_nettype wire
